// file: design/pafs_pkg.sv
package pafs_pkg;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int P5_W = 8;
   localparam int PT9_W = 16;
   localparam int BYTE_W = 8;

   // Register offsets
   localparam logic [3:0] OFS_P5_LATCH = 4'h0;
   localparam logic [3:0] OFS_P5_DIR = 4'h1;
   localparam logic [3:0] OFS_P5_MODE = 4'h2;
   localparam logic [3:0] OFS_P5_FSEL = 4'h3;
   localparam logic [3:0] OFS_P5_LEVEL = 4'h4;
   localparam logic [3:0] OFS_PT9_LATCH = 4'h5;
   localparam logic [3:0] OFS_PT9_LATCH_HI = 4'h6;
   localparam logic [3:0] OFS_PT9_DIR = 4'h7;
   localparam logic [3:0] OFS_PT9_DIR_HI = 4'h8;
   localparam logic [3:0] OFS_PT9_MODE = 4'h9;
   localparam logic [3:0] OFS_PT9_MODE_HI = 4'ha;
   localparam logic [3:0] OFS_PT9_LEVEL = 4'hb;
   localparam logic [3:0] OFS_P5_SEQ_ERR = 4'hc;
   localparam logic [3:0] OFS_P5_UNDEF = 4'hd;

   // Port 5 pins that own a function-select bit
   localparam logic [7:0] P5_FSEL_MASK = 8'h38;

   // Values after reset
   localparam logic [7:0] RST_P5_LATCH = 8'h00;
   localparam logic [7:0] RST_P5_DIR = 8'hff;
   localparam logic [7:0] RST_P5_MODE = 8'h00;
   localparam logic [7:0] RST_P5_FSEL = 8'h00;
   localparam logic [15:0] RST_PT9_LATCH = 16'h0000;
   localparam logic [15:0] RST_PT9_DIR = 16'hffff;
   localparam logic [15:0] RST_PT9_MODE = 16'h0000;
   localparam logic [7:0] RST_SEQ_ERR = 8'h00;
   localparam logic [15:0] RST_RDATA = 16'h0000;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic we;
      logic re;
   } pafs_req_s;

   // Drive of one 16-bit group of pins
   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] oe;
   } pafs_pin_s;

endpackage

// file: design/pafs_sync.sv
`timescale 1ns/1ps
module pafs_sync
#(
   parameter int W = 16
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Asynchronous level in, synchronous level out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   import pafs_pkg::*;

   logic [W-1:0] meta_q;

   // First stage is read by the second stage only
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         meta_q <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

// file: design/pafs_split_reg.sv
`timescale 1ns/1ps
module pafs_split_reg
#(
   parameter logic [15:0] RST = 16'h0000
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Byte writes
   input wire logic lo_we_i,
   input wire logic hi_we_i,
   input wire logic [7:0] lo_d_i,
   input wire logic [7:0] hi_d_i,
   // Stored word
   output logic [15:0] q_o
);
   import pafs_pkg::*;

   // One store for both the word and its high alias
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         q_o <= RST;
      else
      begin
         if (lo_we_i)
            q_o[7:0] <= lo_d_i;
         if (hi_we_i)
            q_o[15:8] <= hi_d_i;
      end
   end

endmodule

// file: design/pafs_top.sv
`timescale 1ns/1ps
module pafs_top
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic [pafs_pkg::ADDR_W-1:0] addr_i,
   input wire logic [pafs_pkg::DATA_W-1:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [pafs_pkg::DATA_W-1:0] rdata_o,
   // Port 5 peripheral side
   input wire logic [pafs_pkg::P5_W-1:0] p5_alt1_dout_i,
   input wire logic [pafs_pkg::P5_W-1:0] p5_alt1_oe_i,
   input wire logic [pafs_pkg::P5_W-1:0] p5_alt2_dout_i,
   input wire logic [pafs_pkg::P5_W-1:0] p5_alt2_oe_i,
   output logic [pafs_pkg::P5_W-1:0] p5_alt_din_o,
   // Port 9 peripheral side
   input wire logic [pafs_pkg::PT9_W-1:0] pt9_alt_dout_i,
   input wire logic [pafs_pkg::PT9_W-1:0] pt9_alt_oe_i,
   output logic [pafs_pkg::PT9_W-1:0] pt9_alt_din_o,
   // Port 5 pins
   input wire logic [pafs_pkg::P5_W-1:0] port5_pin_i,
   output logic [pafs_pkg::P5_W-1:0] port5_pin_o,
   output logic [pafs_pkg::P5_W-1:0] port5_pin_oe_o,
   // Port 9 pins
   input wire logic [pafs_pkg::PT9_W-1:0] port9_pin_i,
   output logic [pafs_pkg::PT9_W-1:0] port9_pin_o,
   output logic [pafs_pkg::PT9_W-1:0] port9_pin_oe_o
);
   import pafs_pkg::*;

   // Per-bit choice between peripheral and port latch or direction
   function automatic logic [15:0] pick
   (
      input logic [15:0] sel,
      input logic [15:0] alt,
      input logic [15:0] gpio
   );
      pick = (sel & alt) | (~sel & gpio);
   endfunction

   // Request bundle
   pafs_req_s req;

   assign req.addr = addr_i;
   assign req.wdata = wdata_i;
   assign req.we = we_i;
   assign req.re = re_i;

   // Write decode
   function automatic logic hit_wr
   (
      input pafs_req_s r,
      input logic [3:0] ofs
   );
      hit_wr = r.we && (r.addr == ofs);
   endfunction

   wire logic wr_p5_latch;
   wire logic wr_p5_dir;
   wire logic wr_p5_mode;
   wire logic wr_p5_fsel;
   wire logic wr_pt9_latch;
   wire logic wr_pt9_latch_hi;
   wire logic wr_pt9_dir;
   wire logic wr_pt9_dir_hi;
   wire logic wr_pt9_mode;
   wire logic wr_pt9_mode_hi;
   wire logic wr_seq_err;

   assign wr_p5_latch = hit_wr(req, OFS_P5_LATCH);
   assign wr_p5_dir = hit_wr(req, OFS_P5_DIR);
   assign wr_p5_mode = hit_wr(req, OFS_P5_MODE);
   assign wr_p5_fsel = hit_wr(req, OFS_P5_FSEL);
   assign wr_pt9_latch = hit_wr(req, OFS_PT9_LATCH);
   assign wr_pt9_latch_hi = hit_wr(req, OFS_PT9_LATCH_HI);
   assign wr_pt9_dir = hit_wr(req, OFS_PT9_DIR);
   assign wr_pt9_dir_hi = hit_wr(req, OFS_PT9_DIR_HI);
   assign wr_pt9_mode = hit_wr(req, OFS_PT9_MODE);
   assign wr_pt9_mode_hi = hit_wr(req, OFS_PT9_MODE_HI);
   assign wr_seq_err = hit_wr(req, OFS_P5_SEQ_ERR);

   // Port 5 registers
   logic [7:0] p5_latch_q;
   logic [7:0] p5_dir_q;
   logic [7:0] p5_mode_q;
   logic [7:0] p5_fsel_q;

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         p5_latch_q <= RST_P5_LATCH;
         p5_dir_q <= RST_P5_DIR;
         p5_mode_q <= RST_P5_MODE;
         p5_fsel_q <= RST_P5_FSEL;
      end
      else
      begin
         if (wr_p5_latch)
            p5_latch_q <= req.wdata[7:0];
         if (wr_p5_dir)
            p5_dir_q <= req.wdata[7:0];
         if (wr_p5_mode)
            p5_mode_q <= req.wdata[7:0];
         // Only pins 3 to 5 have a select bit
         if (wr_p5_fsel)
            p5_fsel_q <= req.wdata[7:0] & P5_FSEL_MASK;
      end
   end

   // Mode bit raised while select still zero: wrong order
   wire logic [7:0] seq_err_set;
   wire logic [7:0] seq_err_clr;
   logic [7:0] seq_err_q;
   logic [7:0] seq_err_d;

   assign seq_err_set = {8{wr_p5_mode}} & req.wdata[7:0] & ~p5_mode_q
      & ~p5_fsel_q & P5_FSEL_MASK;
   assign seq_err_clr = {8{wr_seq_err}} & req.wdata[7:0];
   // Set wins over a clear in the same cycle
   assign seq_err_d = (seq_err_q & ~seq_err_clr) | seq_err_set;

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         seq_err_q <= RST_SEQ_ERR;
      else
         seq_err_q <= seq_err_d;
   end

   // Port 9 registers: word and high alias share one store
   wire logic [15:0] pt9_latch;
   wire logic [15:0] pt9_dir;
   wire logic [15:0] pt9_mode;

   pafs_split_reg #(
      .RST(RST_PT9_LATCH)
   ) u_pt9_latch (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .lo_we_i(wr_pt9_latch),
      .hi_we_i(wr_pt9_latch || wr_pt9_latch_hi),
      .lo_d_i(req.wdata[7:0]),
      .hi_d_i(wr_pt9_latch_hi ? req.wdata[7:0] : req.wdata[15:8]),
      .q_o(pt9_latch)
   );

   pafs_split_reg #(
      .RST(RST_PT9_DIR)
   ) u_pt9_dir (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .lo_we_i(wr_pt9_dir),
      .hi_we_i(wr_pt9_dir || wr_pt9_dir_hi),
      .lo_d_i(req.wdata[7:0]),
      .hi_d_i(wr_pt9_dir_hi ? req.wdata[7:0] : req.wdata[15:8]),
      .q_o(pt9_dir)
   );

   pafs_split_reg #(
      .RST(RST_PT9_MODE)
   ) u_pt9_mode (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .lo_we_i(wr_pt9_mode),
      .hi_we_i(wr_pt9_mode || wr_pt9_mode_hi),
      .lo_d_i(req.wdata[7:0]),
      .hi_d_i(wr_pt9_mode_hi ? req.wdata[7:0] : req.wdata[15:8]),
      .q_o(pt9_mode)
   );

   // Pin level synchronisers
   wire logic [7:0] p5_level;
   wire logic [15:0] pt9_level;

   pafs_sync #(
      .W(P5_W)
   ) u_p5_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i(port5_pin_i),
      .sync_o(p5_level)
   );

   pafs_sync #(
      .W(PT9_W)
   ) u_pt9_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i(port9_pin_i),
      .sync_o(pt9_level)
   );

   // Port 5 alternate source per pin
   wire logic [7:0] p5_undef;
   wire logic [7:0] p5_alt_dout;
   wire logic [7:0] p5_alt_oe;

   // Undefined case is made safe: pin released, driving zero
   assign p5_undef = p5_mode_q & ~p5_fsel_q & P5_FSEL_MASK;

   genvar g;
   generate
      for (g = 0; g < P5_W; g++)
      begin : g_p5_alt
         if (P5_FSEL_MASK[g])
         begin : g_sel
            assign p5_alt_dout[g] = p5_fsel_q[g] & p5_alt2_dout_i[g];
            assign p5_alt_oe[g] = p5_fsel_q[g] & p5_alt2_oe_i[g];
         end
         else
         begin : g_fixed
            assign p5_alt_dout[g] = p5_alt1_dout_i[g];
            assign p5_alt_oe[g] = p5_alt1_oe_i[g];
         end
      end
   endgenerate

   // Pin drive, direction bit high means input
   pafs_pin_s p5_drive;
   pafs_pin_s pt9_drive;

   assign p5_drive.dout = pick({8'h00, p5_mode_q}, {8'h00, p5_alt_dout},
      {8'h00, p5_latch_q});
   assign p5_drive.oe = pick({8'h00, p5_mode_q}, {8'h00, p5_alt_oe},
      {8'h00, ~p5_dir_q});
   assign pt9_drive.dout = pick(pt9_mode, pt9_alt_dout_i, pt9_latch);
   assign pt9_drive.oe = pick(pt9_mode, pt9_alt_oe_i, ~pt9_dir);

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         port5_pin_o <= '0;
         port5_pin_oe_o <= '0;
         port9_pin_o <= '0;
         port9_pin_oe_o <= '0;
         p5_alt_din_o <= '0;
         pt9_alt_din_o <= '0;
      end
      else
      begin
         port5_pin_o <= p5_drive.dout[7:0];
         port5_pin_oe_o <= p5_drive.oe[7:0];
         port9_pin_o <= pt9_drive.dout;
         port9_pin_oe_o <= pt9_drive.oe;
         // Peripherals see the pin only in alternate mode
         p5_alt_din_o <= p5_level & p5_mode_q;
         pt9_alt_din_o <= pt9_level & pt9_mode;
      end
   end

   // Read multiplexer; unmapped offsets read zero
   logic [15:0] rd_mux;

   always_comb
   begin
      rd_mux = 16'h0000;
      unique case (req.addr)
         OFS_P5_LATCH: rd_mux = {8'h00, p5_latch_q};
         OFS_P5_DIR: rd_mux = {8'h00, p5_dir_q};
         OFS_P5_MODE: rd_mux = {8'h00, p5_mode_q};
         OFS_P5_FSEL: rd_mux = {8'h00, p5_fsel_q};
         OFS_P5_LEVEL: rd_mux = {8'h00, p5_level};
         OFS_PT9_LATCH: rd_mux = pt9_latch;
         OFS_PT9_LATCH_HI: rd_mux = {8'h00, pt9_latch[15:8]};
         OFS_PT9_DIR: rd_mux = pt9_dir;
         OFS_PT9_DIR_HI: rd_mux = {8'h00, pt9_dir[15:8]};
         OFS_PT9_MODE: rd_mux = pt9_mode;
         OFS_PT9_MODE_HI: rd_mux = {8'h00, pt9_mode[15:8]};
         OFS_PT9_LEVEL: rd_mux = pt9_level;
         OFS_P5_SEQ_ERR: rd_mux = {8'h00, seq_err_q};
         OFS_P5_UNDEF: rd_mux = {8'h00, p5_undef};
         default: rd_mux = 16'h0000;
      endcase
   end

   // Read data stand for one cycle only
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         rdata_o <= RST_RDATA;
      else if (req.re)
         rdata_o <= rd_mux;
      else
         rdata_o <= RST_RDATA;
   end

endmodule

// file: testbench/pafs_top_monitor.sv
`timescale 1ns/1ps
module pafs_monitor
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [15:0] rdata_o,
   // Port 5 pins
   input wire logic [7:0] port5_pin_o,
   input wire logic [7:0] port5_pin_oe_o
);
   import pafs_pkg::*;

   logic [7:0] mode_q;
   logic [7:0] sel_q;
   wire logic [7:0] undef_w = mode_q & ~sel_q & P5_FSEL_MASK;

   // Shadow copies from bus writes, no peeking inside the design
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         mode_q <= 8'h00;
         sel_q <= 8'h00;
      end
      else if (we_i && addr_i == OFS_P5_MODE)
         mode_q <= wdata_i[7:0];
      else if (we_i && addr_i == OFS_P5_FSEL)
         sel_q <= wdata_i[7:0];
   end

   a_undef_release:
   assert property (@(posedge clk_i) disable iff (!reset_n_i)
      |undef_w |=> ((port5_pin_o | port5_pin_oe_o) & $past(undef_w)) == 8'h00)
      else $error("undefined pin not released");
   a_latch_alias:
   assert property (@(posedge clk_i) disable iff (!reset_n_i)
      we_i && addr_i == OFS_PT9_LATCH_HI ##1 re_i && addr_i == OFS_PT9_LATCH
      |=> rdata_o[15:8] == $past(wdata_i[7:0], 2))
      else $error("latch alias write lost");
   a_dir_alias:
   assert property (@(posedge clk_i) disable iff (!reset_n_i)
      we_i && addr_i == OFS_PT9_DIR_HI ##1 re_i && addr_i == OFS_PT9_DIR
      |=> rdata_o[15:8] == $past(wdata_i[7:0], 2))
      else $error("direction alias write lost");
   a_mode_alias:
   assert property (@(posedge clk_i) disable iff (!reset_n_i)
      we_i && addr_i == OFS_PT9_MODE_HI ##1 re_i && addr_i == OFS_PT9_MODE
      |=> rdata_o[15:8] == $past(wdata_i[7:0], 2))
      else $error("mode alias write lost");
   a_shared_store:
   assert property (@(posedge clk_i) disable iff (!reset_n_i)
      we_i && addr_i == OFS_PT9_LATCH ##1 re_i && addr_i == OFS_PT9_LATCH_HI
      |=> rdata_o == {8'h00, $past(wdata_i[15:8], 2)})
      else $error("alias not sharing word storage");
endmodule

// file: testbench/pafs_top_tb.sv
`timescale 1ns/1ps
module pafs_top_tb;
   import pafs_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [3:0] addr_i = '0;
   logic [15:0] wdata_i = '0;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic [15:0] rdata_o;
   logic [7:0] p5_alt1_dout_i = '0;
   logic [7:0] p5_alt1_oe_i = '0;
   logic [7:0] p5_alt2_dout_i = '0;
   logic [7:0] p5_alt2_oe_i = '0;
   logic [7:0] p5_alt_din_o;
   logic [15:0] pt9_alt_dout_i = '0;
   logic [15:0] pt9_alt_oe_i = '0;
   logic [15:0] pt9_alt_din_o;
   logic [7:0] port5_pin_i = '0;
   logic [7:0] port5_pin_o;
   logic [7:0] port5_pin_oe_o;
   logic [15:0] port9_pin_i = '0;
   logic [15:0] port9_pin_o;
   logic [15:0] port9_pin_oe_o;
   int bad_count = 0;
   int compares = 0;

   pafs_top u_pafs_top (.clk_i, .reset_n_i, .addr_i, .wdata_i, .we_i,
      .re_i, .rdata_o, .p5_alt1_dout_i, .p5_alt1_oe_i, .p5_alt2_dout_i,
      .p5_alt2_oe_i, .p5_alt_din_o, .pt9_alt_dout_i, .pt9_alt_oe_i,
      .pt9_alt_din_o, .port5_pin_i, .port5_pin_o, .port5_pin_oe_o,
      .port9_pin_i, .port9_pin_o, .port9_pin_oe_o);

   initial
   begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Reads leave one idle cycle so the next access never raises its strobe as re_i falls
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      re_i <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o, e);
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Write then read with no gap between the strobes
   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d,
      input logic [3:0] b, input logic [15:0] e);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
      rd(b, e);
   endtask

   task automatic t_reset();
      rd(OFS_PT9_DIR, RST_PT9_DIR);
      rd(OFS_PT9_DIR_HI, 16'h00ff);
      rd(OFS_PT9_MODE_HI, 16'h0000);
   endtask

   task automatic t_latch();
      wr_rd(OFS_PT9_LATCH, 16'h1234, OFS_PT9_LATCH_HI, 16'h0012);
      wr_rd(OFS_PT9_LATCH_HI, 16'hff5a, OFS_PT9_LATCH, 16'h5a34);
      wr(OFS_PT9_DIR, 16'h00ff);
      @(negedge clk_i);
      chk(port9_pin_o, 16'h5a34);
      chk(port9_pin_oe_o, 16'hff00);
      @(posedge clk_i);
   endtask

   task automatic t_dir();
      wr_rd(OFS_PT9_DIR, 16'hc3c3, OFS_PT9_DIR_HI, 16'h00c3);
      wr_rd(OFS_PT9_DIR_HI, 16'hf00f, OFS_PT9_DIR, 16'h0fc3);
      @(negedge clk_i);
      chk(port9_pin_oe_o, 16'hf03c);
      @(posedge clk_i);
   endtask

   task automatic t_mode();
      pt9_alt_dout_i <= 16'h8000;
      pt9_alt_oe_i <= 16'h0001;
      wr_rd(OFS_PT9_MODE, 16'h0001, OFS_PT9_MODE_HI, 16'h0000);
      wr_rd(OFS_PT9_MODE_HI, 16'h0080, OFS_PT9_MODE, 16'h8001);
      @(negedge clk_i);
      chk(port9_pin_o, 16'hda34);
      chk(port9_pin_oe_o, 16'h703d);
      @(posedge clk_i);
   endtask

   task automatic t_p5();
      p5_alt2_dout_i <= 8'h28;
      p5_alt2_oe_i <= 8'hff;
      wr(OFS_P5_DIR, 16'h0000);
      wr(OFS_P5_LATCH, 16'h00ff);
      wr(OFS_P5_MODE, 16'h0038);
      @(negedge clk_i);
      chk({port5_pin_oe_o, port5_pin_o}, 16'hc7c7);
      @(posedge clk_i);
      rd(OFS_P5_SEQ_ERR, 16'h0038);
      rd(OFS_P5_UNDEF, 16'h0038);
      wr(OFS_P5_MODE, 16'h0000);
      wr(OFS_P5_FSEL, 16'h00ff);
      wr(OFS_P5_MODE, 16'h0038);
      rd(OFS_P5_FSEL, 16'h0038);
      wr_rd(OFS_P5_SEQ_ERR, 16'h00ff, OFS_P5_SEQ_ERR, 16'h0000);
      rd(OFS_P5_UNDEF, 16'h0000);
      @(negedge clk_i);
      chk({port5_pin_oe_o, port5_pin_o}, 16'hffef);
      @(posedge clk_i);
   endtask

   // Pin levels, alternate inputs and alternate function 1
   task automatic t_level();
      port5_pin_i <= 8'hff;
      port9_pin_i <= 16'hffff;
      p5_alt1_dout_i <= 8'h41;
      p5_alt1_oe_i <= 8'hc0;
      wr(OFS_P5_MODE, 16'h00ff);
      rd(OFS_P5_LEVEL, 16'h00ff);
      rd(OFS_PT9_LEVEL, 16'hffff);
      @(negedge clk_i);
      chk({port5_pin_oe_o, port5_pin_o}, 16'hf869);
      chk({8'h00, p5_alt_din_o}, 16'h00ff);
      chk(pt9_alt_din_o, 16'h8001);
      @(posedge clk_i);
   endtask

   initial
   begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_latch();
      t_dir();
      t_mode();
      t_p5();
      t_level();
      tally_and_finish();
   end

   // Whole run is well under a hundred cycles
   initial
   begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
endmodule

bind pafs_top pafs_monitor u_pafs_monitor (.clk_i, .reset_n_i, .addr_i,
   .wdata_i, .we_i, .re_i, .rdata_o, .port5_pin_o, .port5_pin_oe_o);
